// file: readout_pkg.sv
/*
 * shared constants, register map and carrier types for the window and
 * subsample readout block.
 * assumes a 10 MHz system clock and a single AHB-Lite slave port.
 */
`default_nettype none
package readout_pkg;
	// register byte addresses
	localparam logic [7:0] CTRL_ADDR   = 8'h00;
	localparam logic [7:0] WINDOW_ADDR = 8'h04;
	localparam logic [7:0] GAIN_ADDR   = 8'h08;
	localparam logic [7:0] DAC_ADDR    = 8'h0c;
	localparam logic [7:0] STATUS_ADDR = 8'h10;

	// window field positions
	localparam int COL_IDX_LSB = 0;
	localparam int ROW_IDX_LSB = 8;
	localparam int ROW_POS_LSB = 16;

	// grid of start positions
	localparam int          ADDR_W      = 12;
	localparam logic [6:0]  COL_IDX_MAX = 7'h62;   // 99 positions
	localparam logic [7:0]  ROW_IDX_MAX = 8'h89;   // 138 positions
	localparam logic [4:0]  BLOCK_PIX   = 5'h18;   // pattern repeat width

	// row blanking time
	localparam int          CLK_NS      = 100;
	localparam int          RBT_NS      = 7200;
	localparam int          RBT_CYCLES  = (RBT_NS + CLK_NS - 1) / CLK_NS;

	// reset values
	localparam logic [3:0]  GAIN_RESET  = 4'h0;
	localparam logic [7:0]  DAC_RESET   = 8'h00;

	typedef struct packed {
		logic       calibrate;
		logic [2:0] subsample;
		logic       single_adc;
		logic       amp_standby;
		logic       one_out;
		logic       nondestructive_readout;
	} cfg_t;

	localparam cfg_t CFG_RESET = '0;

	typedef struct packed {
		logic [7:0] dark;
		logic [7:0] fine;
		logic [7:0] raw;
	} dac_t;

	// step between pixel pairs for a subsample code
	function automatic logic [4:0] step_of(input logic [2:0] code);
		if (code[2])
			return 5'h0c;
		else if (code == 3'h3)
			return 5'h08;
		else if (code == 3'h2)
			return 5'h06;
		else if (code == 3'h1)
			return 5'h04;
		else
			return 5'h02;
	endfunction

	// column start address from its index: index times 24
	function automatic logic [ADDR_W-1:0] col_base(input logic [6:0] idx);
		return ADDR_W'({idx, 4'h0}) + ADDR_W'({idx, 3'h0});
	endfunction
endpackage
`default_nettype wire

// file: subsample_stepper.sv
/*
 * address stepper for one shift register direction.
 * assumes load and advance are single-cycle strobes synchronous to clk.
 */
`default_nettype none
module subsample_stepper
	import readout_pkg::*;
#(
	parameter int W      = 12,
	parameter bit PAIRED = 1'b1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic         load,
	input  wire logic [W-1:0] base,
	input  wire logic         advance,
	input  wire logic [4:0]   step,
	output logic      [W-1:0] addr
);
	logic phase;

	// refused at elaboration: a narrower stepper cannot hold the last start address
	if (W < 8) begin : g_bad_width
		$error("stepper width too small");
	end

	// paired: both columns move together, so the pair jumps by the full step.
	// single: rows go one at a time, two adjacent rows then the skip.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr  <= '0;
			phase <= 1'b0;
		end else if (ce) begin
			if (load) begin
				addr  <= base;
				phase <= 1'b0;
			end else if (advance) begin
				if (PAIRED)
					addr <= addr + W'(step);
				else if (!phase)
					addr <= addr + W'(1);
				else
					addr <= addr + W'(step - 5'h01);
				phase <= PAIRED ? 1'b0 : !phase;
			end
		end
	end
endmodule
`default_nettype wire

// file: pixel_window_subsample_readout.sv
/*
 * readout addressing and output configuration with an AHB-Lite register port.
 * assumes frame_start, row_clock and pixel_tick are synchronous one-cycle
 * strobes from the camera controller; hready is this slave's own hreadyout.
 */
// What this block does
// - frame start loads the programmed row start address into the row register
// - each row clock selects next row, starts blanking, loads column start
// - column start in steps of 24 on even addresses, row start in steps of 1
// - after reset the output multiplexer uses two separate outputs
// - single-output bit merges both buses onto output 1, idles second path
// - amplifier standby bit puts the whole output chain in standby
// - gain chosen by 4-bit code, 0000 lowest to 1111 highest
// - each offset DAC takes an 8-bit code
// - during amplifier calibration the dark DAC level drives the buses, except in nondestructive mode
// - nondestructive mode ties bus references to the fine DAC continuously
// - two converters split even and odd columns, or one takes all
// - 3-bit code picks step 2, 4, 6, 8 or 12, two pixels each
// - columns addressed in pairs onto both buses, rows one at a time
// - 99 column and 138 row starting positions
// - subsample patterns repeat over a 24-pixel block
`default_nettype none
module pixel_window_subsample_readout
	import readout_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic      [31:0]       hrdata,
	output logic                   hresp,
	input  wire logic              frame_start,
	input  wire logic              row_clock,
	input  wire logic              pixel_tick,
	output logic      [ADDR_W-1:0] row_addr,
	output logic      [ADDR_W-1:0] col_addr,
	output logic                   row_blank,
	output logic                   mux_odd,
	output logic                   out2_standby,
	output logic                   amp_standby,
	output logic      [3:0]        gain_code,
	output dac_t                   dac_code,
	output logic                   ref_to_fine,
	output logic                   drive_dark,
	output logic                   adc_even_en,
	output logic                   adc_odd_en
);
	cfg_t       cfg;
	dac_t       dac;
	logic [3:0] gain;
	logic [6:0] col_start;
	logic [7:0] row_start;
	logic [6:0] col_start_act;
	logic [2:0] sub_act;
	logic       one_out_act;
	logic [6:0] blank_cnt;
	logic       wr_pend;
	logic [7:0] wr_addr;
	logic       next_accept;
	logic [4:0] step;
	logic       col_advance;

	if (RBT_CYCLES < 1 || RBT_CYCLES > 127) begin : g_bad_blank
		$error("blanking count does not fit its counter");
	end

	// bus slave: zero wait states, reads answered from a flip-flop in the data phase
	assign next_accept = hsel && htrans[1] && hready;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
		end else if (ce) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= next_accept && hwrite && hsize == 3'h2 && haddr[31:8] == 24'h00_0000;
			wr_addr   <= haddr[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (ce) begin
			if (!next_accept || hwrite)
				hrdata <= 32'h0000_0000;
			else if (haddr[31:8] != 24'h00_0000)
				hrdata <= 32'h0000_0000;
			else if (haddr[7:0] == CTRL_ADDR)
				hrdata <= {24'h00_0000, cfg};
			else if (haddr[7:0] == WINDOW_ADDR)
				hrdata <= {16'h0000, row_start, 1'b0, col_start};
			else if (haddr[7:0] == GAIN_ADDR)
				hrdata <= {28'h000_0000, gain};
			else if (haddr[7:0] == DAC_ADDR)
				hrdata <= {8'h00, dac};
			else if (haddr[7:0] == STATUS_ADDR)
				hrdata <= {4'h0, row_addr, 3'h0, row_blank, col_addr};
			else
				hrdata <= 32'h0000_0000;
		end
	end

	// writable settings; out-of-range start indices are clamped to the last position
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg       <= CFG_RESET;
			gain      <= GAIN_RESET;
			dac       <= {DAC_RESET, DAC_RESET, DAC_RESET};
			col_start <= 7'h00;
			row_start <= 8'h00;
		end else if (ce && wr_pend) begin
			if (wr_addr == CTRL_ADDR)
				cfg <= hwdata[7:0];
			else if (wr_addr == WINDOW_ADDR) begin
				col_start <= (hwdata[COL_IDX_LSB +: 7] > COL_IDX_MAX)
					? COL_IDX_MAX : hwdata[COL_IDX_LSB +: 7];
				row_start <= (hwdata[ROW_IDX_LSB +: 8] > ROW_IDX_MAX)
					? ROW_IDX_MAX : hwdata[ROW_IDX_LSB +: 8];
			end else if (wr_addr == GAIN_ADDR)
				gain <= hwdata[3:0];
			else if (wr_addr == DAC_ADDR)
				dac <= hwdata[23:0];
		end
	end

	// window and pattern are taken at frame start so a frame never mixes settings
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			col_start_act <= 7'h00;
			sub_act       <= 3'h0;
			one_out_act   <= 1'b0;
		end else if (ce && frame_start) begin
			col_start_act <= col_start;
			sub_act       <= cfg.subsample;
			one_out_act   <= cfg.one_out;
		end
	end

	assign step = step_of(sub_act);

	// the row start is a plain index, any row can open a window
	subsample_stepper #(
		.W      (ADDR_W),
		.PAIRED (1'b0)
	) u_rows (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.load    (frame_start),
		.base    (ADDR_W'(row_start)),
		.advance (row_clock),
		.step    (step),
		.addr    (row_addr)
	);

	// steps divide 24 and starts sit on 24-pixel blocks, so edges never move
	subsample_stepper #(
		.W      (ADDR_W),
		.PAIRED (1'b1)
	) u_cols (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.load    (row_clock || frame_start),
		// at frame start the latched copy is still the old one, so take the register itself
		.base    (col_base(frame_start ? col_start : col_start_act)),
		.advance (col_advance),
		.step    (step),
		.addr    (col_addr)
	);

	// one output carries both bus signals alternately, so a pair takes two ticks
	assign col_advance = pixel_tick && !row_clock && !frame_start && !row_blank
		&& (!one_out_act || mux_odd);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mux_odd <= 1'b0;
		end else if (ce) begin
			if (row_clock || frame_start || !one_out_act)
				mux_odd <= 1'b0;
			else if (pixel_tick && !row_blank)
				mux_odd <= !mux_odd;
		end
	end

	// row blanking: fixed length after each row clock, pixels wait it out
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			blank_cnt <= 7'h00;
			row_blank <= 1'b0;
		end else if (ce) begin
			if (row_clock) begin
				blank_cnt <= 7'(RBT_CYCLES - 1);
				row_blank <= 1'b1;
			end else if (blank_cnt != 7'h00) begin
				blank_cnt <= blank_cnt - 7'h01;
			end else begin
				row_blank <= 1'b0;
			end
		end
	end

	// analog configuration outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out2_standby <= 1'b0;
			amp_standby  <= 1'b0;
			gain_code    <= GAIN_RESET;
			dac_code     <= {DAC_RESET, DAC_RESET, DAC_RESET};
			ref_to_fine  <= 1'b0;
			drive_dark   <= 1'b0;
			adc_even_en  <= 1'b1;
			adc_odd_en   <= 1'b1;
		end else if (ce) begin
			amp_standby  <= cfg.amp_standby;
			out2_standby <= cfg.amp_standby || cfg.one_out;
			gain_code    <= gain;
			dac_code     <= dac;
			ref_to_fine  <= cfg.nondestructive_readout;
			// in nondestructive mode references stay on the fine DAC, not the dark level
			drive_dark   <= (cfg.calibrate || row_blank) && !cfg.nondestructive_readout;
			adc_even_en  <= !cfg.amp_standby;
			adc_odd_en   <= !cfg.amp_standby && !cfg.single_adc;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_row_edge;
		ce && row_clock && !frame_start;
	endsequence

	sequence s_cols_reloaded;
		col_addr == col_base(col_start_act) && row_blank;
	endsequence

	a_frame_row_load: assert property (ce && frame_start |=> row_addr == ADDR_W'($past(row_start)))
		else $error("row register not loaded at frame start");

	a_frame_col_load: assert property (ce && frame_start |=> col_addr == col_base($past(col_start)))
		else $error("column start not loaded at frame start");

	a_row_col_reload: assert property (s_row_edge |=> s_cols_reloaded)
		else $error("column start not reloaded on row clock");

	a_row_next: assert property (s_row_edge ##0 !$past(row_clock) |=> row_addr != $past(row_addr))
		else $error("row clock did not select a new row");

	a_col_grid: assert property (col_start <= COL_IDX_MAX && row_start <= ROW_IDX_MAX)
		else $error("start index beyond last position");

	a_col_even: assert property (col_addr[0] == 1'b0)
		else $error("column pair address is odd");

	a_one_out_idle: assert property (ce && cfg.one_out |=> out2_standby)
		else $error("second output path not idled in single-output mode");

	a_amp_chain: assert property (ce && cfg.amp_standby |=> amp_standby && out2_standby && !adc_even_en)
		else $error("amplifier chain not in standby");

	a_gain_code: assert property (ce ##1 ce |-> gain_code == $past(gain))
		else $error("gain code does not follow its register");

	a_dark_drive: assert property (ce && cfg.calibrate && !cfg.nondestructive_readout |=> drive_dark)
		else $error("dark level not driven during calibration");

	a_ndr_ref: assert property (ce && cfg.nondestructive_readout |=> ref_to_fine && !drive_dark)
		else $error("references not tied to fine DAC");

	a_adc_split: assert property (ce && !cfg.single_adc && !cfg.amp_standby |=> adc_odd_en && adc_even_en)
		else $error("odd converter disabled in split mode");

	a_col_step: assert property (ce && col_advance |=> col_addr == $past(col_addr) + ADDR_W'(step))
		else $error("column pair did not move by the subsample step");

	a_blank_len: assert property (ce && row_clock ##1 (ce && !row_clock) [*8] |-> row_blank)
		else $error("row blanking ended early");
endmodule
`default_nettype wire

// file: camera_controller_model.sv
/*
 * camera controller model: one-cycle frame, row and pixel strobes.
 * assumes the bench owns clk and that calls come from one process.
 */
`default_nettype none
module camera_controller_model (
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      frame_start,
	output logic      row_clock,
	output logic      pixel_tick
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		frame_start = 1'b0;
		row_clock = 1'b0;
		pixel_tick = 1'b0;
	end

	// which: 0 frame start, 1 row clock, other pixel tick
	task automatic strobe(input int which);
		wait (rst_n === 1'b1);
		@(posedge clk);
		case (which)
			0: frame_start <= 1'b1;
			1: row_clock <= 1'b1;
			default: pixel_tick <= 1'b1;
		endcase
		@(posedge clk);
		frame_start <= 1'b0;
		row_clock <= 1'b0;
		pixel_tick <= 1'b0;
	endtask

	// gap+1 idle cycles between ticks; a larger gap stands for a slow controller
	task automatic ticks(input int n, input int gap);
		for (int i = 0; i < n; i++) begin
			strobe(2);
			repeat (gap) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// file: test_pixel_window_subsample_readout.sv
/*
 * self-checking bench for the readout block: registers over AHB-Lite,
 * strobes from the camera controller model.
 * assumes hreadyout is the only slave on the bus and is fed back as hready.
 */
`default_nettype none
module test_pixel_window_subsample_readout;
	timeunit 1ns;
	timeprecision 100ps;
	import readout_pkg::*;

	logic              clk, rst_n, ce, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0]       haddr, hwdata, hrdata, d;
	logic [1:0]        htrans;
	logic [2:0]        hsize;
	logic              frame_start, row_clock, pixel_tick, row_blank, mux_odd;
	logic              out2_standby, amp_standby, ref_to_fine, drive_dark;
	logic              adc_even_en, adc_odd_en;
	logic [ADDR_W-1:0] row_addr, col_addr, base, stp;
	logic [3:0]        gain_code;
	dac_t              dac_code;
	logic [23:0]       dv;
	logic [6:0]        ci;
	logic [7:0]        ri, cv;
	int                error_cnt, tests_run, n;
	logic [7:0]        ctl_tab [5] = '{8'h04, 8'h01, 8'h80, 8'h81, 8'h08};
	logic [5:0]        exp_tab [5] = '{6'h30, 6'h0b, 6'h07, 6'h0b, 6'h02};

	assign hready = hreadyout;

	pixel_window_subsample_readout dut (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .frame_start(frame_start),
		.row_clock(row_clock), .pixel_tick(pixel_tick), .row_addr(row_addr), .col_addr(col_addr),
		.row_blank(row_blank), .mux_odd(mux_odd), .out2_standby(out2_standby),
		.amp_standby(amp_standby), .gain_code(gain_code), .dac_code(dac_code),
		.ref_to_fine(ref_to_fine), .drive_dark(drive_dark), .adc_even_en(adc_even_en),
		.adc_odd_en(adc_odd_en));

	camera_controller_model cam (.clk(clk), .rst_n(rst_n), .frame_start(frame_start),
		.row_clock(row_clock), .pixel_tick(pixel_tick));

	// 10 MHz stands in for the controller's pixel-rate clock
	always #50 clk = ~clk;

	function automatic logic [11:0] exp_step(input logic [2:0] code);
		case (code)
			3'h0: return 12'h002;
			3'h1: return 12'h004;
			3'h2: return 12'h006;
			3'h3: return 12'h008;
			default: return 12'h00c;
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic settle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// one single transfer; read data taken at the edge that ends the data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test();
	end

	initial begin
		{clk, rst_n, hsel, hwrite, htrans} = '0;
		{haddr, hwdata} = '0;
		ce = 1'b1;
		hsize = 3'h2;
		error_cnt = 0;
		tests_run = 0;
		void'($urandom(32'h00ab9e1e));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		settle(1);
		chk({out2_standby, mux_odd, adc_even_en, adc_odd_en}, 32'h3, "two-output default");
		for (int a = 0; a < 24; a += 4) begin
			bus(1'b0, 8'(a), 32'h0, d);
			chk(d, 32'h0, "reset or unmapped read");
			chk({hreadyout, hresp}, 32'h2, "okay response");
		end
		$display("test reset done");

		for (int g = 0; g < 16; g++) begin
			dv = (g == 0) ? 24'h000000 : (g == 15) ? 24'hffffff : 24'($urandom());
			bus(1'b1, GAIN_ADDR, 32'(g), d);
			bus(1'b1, DAC_ADDR, {8'h00, dv}, d);
			settle(2);
			chk(gain_code, 32'(g), "gain code");
			chk(dac_code, dv, "dac codes");
			bus(1'b0, GAIN_ADDR, 32'h0, d);
			chk(d, 32'(g), "gain readback");
			bus(1'b0, DAC_ADDR, 32'h0, d);
			chk(d, {8'h00, dv}, "dac readback");
		end
		// indices past the last start position read back as the last one
		bus(1'b1, WINDOW_ADDR, 32'h0000_ff7f, d);
		bus(1'b0, WINDOW_ADDR, 32'h0, d);
		chk(d, {16'h0000, 8'h89, 1'b0, 7'h62}, "start clamp");
		$display("test gain and offset done");

		for (int i = 0; i < 5; i++) begin
			bus(1'b1, CTRL_ADDR, {24'h0, ctl_tab[i]}, d);
			settle(2);
			chk({amp_standby, out2_standby, ref_to_fine, drive_dark, adc_even_en, adc_odd_en},
				exp_tab[i], "control outputs");
		end
		$display("test control bits done");

		// codes 4..7 all land on the widest step; 6 and 7 run single-output
		for (int k = 0; k < 8; k++) begin
			ci = (k == 0) ? 7'h62 : (k == 1) ? 7'h00 : 7'($urandom_range(98));
			ri = (k == 0) ? 8'h89 : 8'($urandom_range(137));
			cv = {1'b0, 3'(k), 4'h0} | ((k >= 6) ? 8'h02 : 8'h00);
			base = 12'(ci) * 12'h018;
			stp = exp_step(3'(k));
			bus(1'b1, WINDOW_ADDR, {16'h0, ri, 1'b0, ci}, d);
			bus(1'b1, CTRL_ADDR, {24'h0, cv}, d);
			cam.strobe(0);
			settle(2);
			chk(row_addr, 12'(ri), "row start");
			chk(col_addr, base, "column start");
			chk(out2_standby, (k >= 6), "second path standby");
			cam.strobe(1);
			settle(0);
			n = 0;
			while (row_blank === 1'b1 && n < 200) begin
				n++;
				settle(1);
			end
			chk(n, RBT_CYCLES, "blanking length");
			chk(row_addr, 12'(ri) + 12'h001, "next row");
			chk(col_addr, base, "column reload");
			chk(drive_dark, 1'b1, "dark level in blanking");
			bus(1'b0, STATUS_ADDR, 32'h0, d);
			chk(d, {4'h0, 12'(ri) + 12'h001, 3'h0, 1'b0, base}, "status");
			if (k < 6) begin
				cam.ticks(2, k);
				settle(1);
				chk(col_addr, base + stp + stp, "pair step");
			end else begin
				cam.ticks(1, 0);
				settle(1);
				chk({mux_odd, col_addr}, {1'b1, base}, "odd half");
				cam.ticks(1, 2);
				settle(1);
				chk({mux_odd, col_addr}, {1'b0, base + stp}, "merged step");
			end
			cam.strobe(1);
			settle(1);
			chk(row_addr, 12'(ri) + stp, "row skip");
		end
		$display("test window and subsample done");
		finish_test();
	end
endmodule
`default_nettype wire
